// File: design/pdwc_pkg.sv
// Constants and types for the power-down and wake-up sequencer.
// Assumes a single 100 MHz clock and an APB master on the register side.
// Summary of operation
// - Standby entered only by halt instruction.
// - Halt stops oscillator, freezes at halt.
// - Standby preserves memory, registers, port states.
// - Halt clears watchdog; RC keeps, system clock stops.
// - Halt sets power-down, clears watchdog-expired flag.
// - Wake on reset, Port A fall, interrupt, watchdog.
// - Reset wake full reset; watchdog wake watchdog reset.
// - Power-down flag cleared by power-up or clear-watchdog.
// - Watchdog expiry sets flag; standby wake resets PC/SP.
// - Per-pin Port A wake enable; resume after halt.
// - Disabled interrupt or full stack resumes after halt.
// - Enabled interrupt with stack room vectors normally.
// - Already-pending interrupt cannot wake this standby.
// - Wait 1024 clocks after wake, then resume.
// - Interrupt service entry one extra cycle later.
// - Frequency-select bit picks 6 or 12 MHz.
// - Watchdog RC runs in standby unless disabled.
// - Standby watchdog reset sets both flags.
package pdwc_pkg;
	localparam logic [11:0] PDWC_CTRL_ADDR = 12'h000;
	localparam logic [11:0] PDWC_STAT_ADDR = 12'h004;
	localparam logic [11:0] PDWC_WAKE_ADDR = 12'h008;
	localparam int PDWC_RESTART_CYCLES = 1024;
	localparam int PDWC_IRQ_EXTRA_CYCLES = 1;
	localparam int PDWC_FREQ_SEL_BIT = 0;
	localparam int PDWC_RC_DIS_BIT = 1;
	localparam int PDWC_WD_RC_SRC_BIT = 2;
	localparam int PDWC_PDOWN_BIT = 0;
	localparam int PDWC_EXPIRED_BIT = 1;
	localparam int PDWC_STANDBY_BIT = 2;
	localparam logic [2:0] PDWC_CTRL_RESET = 3'h4;
	localparam logic [7:0] PDWC_WAKE_RESET = 8'h00;
	// Resume codes.
	localparam logic [1:0] PDWC_RES_NONE = 2'h0;
	localparam logic [1:0] PDWC_RES_NEXT = 2'h1;
	localparam logic [1:0] PDWC_RES_VECTOR = 2'h2;
	localparam logic [1:0] PDWC_RES_RESET = 2'h3;
	typedef enum logic [3:0] {
		PDWC_RUN = 4'h1,
		PDWC_STANDBY = 4'h2,
		PDWC_RESTART = 4'h4,
		PDWC_VECTOR = 4'h8
	} pdwc_state_type;
endpackage : pdwc_pkg

// File: design/pdwc_power_down_wake_control.sv
// Power-down and wake-up sequencer with an APB register slave.
// Assumes the core reports halt, clear-watchdog and interrupt state by pulses
// and levels synchronous to the clock, and obeys the stall output.
//
// The APB register port and the register offsets were decided locally.
`timescale 1ns/100ps
module pdwc_power_down_wake_control
	import pdwc_pkg::*;
#(
	parameter int PORT_WIDTH = 8,
	parameter int IRQ_COUNT = 4,
	parameter int RESTART_CYCLES = PDWC_RESTART_CYCLES
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic powerUp,
	input wire logic [11:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic haltExec,
	input wire logic clearWatchdog,
	input wire logic extReset,
	input wire logic [PORT_WIDTH-1:0] portA,
	input wire logic [IRQ_COUNT-1:0] irqRequest,
	input wire logic [IRQ_COUNT-1:0] irqEnable,
	input wire logic stackFull,
	input wire logic watchdogOverflow,
	output logic sysOscEnable,
	output logic core_freq_select,
	output logic watchdogRcEnable,
	output logic watchdogClear,
	output logic watchdogRun,
	output logic coreStall,
	output logic holdState,
	output logic fullReset,
	output logic watchdogReset,
	output logic resumeNext,
	output logic vectorIrq,
	output logic power_down_flag,
	output logic watchdog_expired_flag
);
	initial begin
		if (PORT_WIDTH < 1 || PORT_WIDTH > 32) begin
			$error("pdwc: port width must be 1 to 32");
		end
		if (IRQ_COUNT < 1 || IRQ_COUNT > 32) begin
			$error("pdwc: request count must be 1 to 32");
		end
		// A restart of one cycle leaves no room to count to the end.
		if (RESTART_CYCLES < 2) begin
			$error("pdwc: restart delay too short");
		end
	end

	// ------------------------------------------------------------
	// Register bus
	// ------------------------------------------------------------
	logic [2:0] control;
	logic [PORT_WIDTH-1:0] wakeEnable;
	pdwc_state_type state;
	pdwc_state_type next_state;
	wire isCtrl = (paddr == PDWC_CTRL_ADDR);
	wire isStat = (paddr == PDWC_STAT_ADDR);
	wire isWake = (paddr == PDWC_WAKE_ADDR);
	wire mapped = isCtrl | isStat | isWake;
	wire access = psel & penable;
	wire wrCtrl = access & pwrite & isCtrl;
	wire wrWake = access & pwrite & isWake;
	wire inStandby = (state == PDWC_STANDBY);
	logic [31:0] statWord;
	always_comb begin
		statWord = 32'h0;
		statWord[PDWC_PDOWN_BIT] = power_down_flag;
		statWord[PDWC_EXPIRED_BIT] = watchdog_expired_flag;
		statWord[PDWC_STANDBY_BIT] = inStandby;
	end
	wire [31:0] ctrlWord = {29'h0, control};
	wire [31:0] wakeWord = {{(32-PORT_WIDTH){1'b0}}, wakeEnable};
	wire [31:0] readWord = isCtrl ? ctrlWord :
		isStat ? statWord :
		isWake ? wakeWord : 32'h0;
	// Every access completes at once, so the bus never waits on standby.
	assign pready = 1'b1;
	// Unmapped offsets answer with an error so a stray access is visible.
	assign pslverr = access & ~mapped;

	always_ff @(posedge clock) begin
		if (rst) begin
			prdata <= 32'h0;
		end else if (psel & ~penable & ~pwrite) begin
			prdata <= readWord;
		end
	end

	// Configuration is only ever changed by software over the bus.
	always_ff @(posedge clock) begin
		if (rst) begin
			control <= PDWC_CTRL_RESET;
		end else if (wrCtrl) begin
			control <= pwdata[2:0];
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			wakeEnable <= PORT_WIDTH'(PDWC_WAKE_RESET);
		end else if (wrWake) begin
			wakeEnable <= pwdata[PORT_WIDTH-1:0];
		end
	end
	assign core_freq_select = control[PDWC_FREQ_SEL_BIT];
	wire rcDisabled = control[PDWC_RC_DIS_BIT];
	wire wdFromRc = control[PDWC_WD_RC_SRC_BIT] & ~rcDisabled;

	// ------------------------------------------------------------
	// Wake detection
	// ------------------------------------------------------------
	logic [PORT_WIDTH-1:0] portPrev;
	logic [IRQ_COUNT-1:0] irqMasked;
	logic [1:0] resumeKind;
	logic [$clog2(RESTART_CYCLES+1)-1:0] restartCount;
	// Pin history resets high, the idle level, so reset makes no false edge.
	logic [PORT_WIDTH-1:0] portFall;
	logic [IRQ_COUNT-1:0] irqWake;
	// One detector per pin: a falling edge on an enabled pin wakes.
	for (genvar p = 0; p < PORT_WIDTH; p++) begin : g_pin
		assign portFall[p] = portPrev[p] & ~portA[p] & wakeEnable[p];
	end
	// A request already pending at halt is masked for this standby.
	for (genvar q = 0; q < IRQ_COUNT; q++) begin : g_irq
		assign irqWake[q] = irqRequest[q] & ~irqMasked[q];
	end
	wire irqVectorOk = |(irqWake & irqEnable) & ~stackFull;
	wire wdWake = watchdogOverflow & wdFromRc;
	wire anyWake = extReset | (|portFall) | (|irqWake) | wdWake;
	wire restartDone = (restartCount == 
		($clog2(RESTART_CYCLES+1))'(RESTART_CYCLES - 1));

	always_ff @(posedge clock) begin
		if (rst) begin
			portPrev <= '1;
			irqMasked <= '0;
		end else begin
			portPrev <= portA;
			if (state == PDWC_RUN && haltExec) begin
				irqMasked <= irqRequest;
			end
		end
	end

	// ------------------------------------------------------------
	// Sequencer
	// ------------------------------------------------------------
	always_comb begin
		next_state = state;
		unique case (state)
			PDWC_RUN: begin
				if (haltExec) begin
					next_state = PDWC_STANDBY;
				end
			end
			PDWC_STANDBY: begin
				if (anyWake) begin
					next_state = PDWC_RESTART;
				end
			end
			PDWC_RESTART: begin
				if (restartDone) begin
					next_state = (resumeKind == PDWC_RES_VECTOR) ?
						PDWC_VECTOR : PDWC_RUN;
				end
			end
			PDWC_VECTOR: begin
				next_state = PDWC_RUN;
			end
			default: begin
				next_state = PDWC_RUN;
			end
		endcase
	end

	// Entry to standby is only by halt; nothing else moves the state to standby.
	always_ff @(posedge clock) begin
		if (rst) begin
			state <= PDWC_RUN;
		end else begin
			state <= next_state;
		end
	end

	// The count clears on the wake out of standby; wakes during restart neither clear nor shorten it.
	always_ff @(posedge clock) begin
		if (rst) begin
			restartCount <= '0;
			resumeKind <= PDWC_RES_NONE;
		end else begin
			if (inStandby && anyWake) begin
				restartCount <= '0;
				if (extReset) begin
					resumeKind <= PDWC_RES_RESET;
				end else if (wdWake) begin
					resumeKind <= PDWC_RES_RESET;
				end else if (|portFall || !irqVectorOk) begin
					resumeKind <= PDWC_RES_NEXT;
				end else begin
					resumeKind <= PDWC_RES_VECTOR;
				end
			end else if (state == PDWC_RESTART && !restartDone) begin
				restartCount <= restartCount + 1'b1;
			end
		end
	end

	// ------------------------------------------------------------
	// Wake reason
	// ------------------------------------------------------------
	// Wake reason latches feed the reset outputs at the end of restart.
	logic wakeByExt;
	logic wakeByWd;
	always_ff @(posedge clock) begin
		if (rst) begin
			wakeByExt <= 1'b0;
			wakeByWd <= 1'b0;
		end else if (inStandby && anyWake) begin
			wakeByExt <= extReset;
			wakeByWd <= ~extReset & wdWake;
		end
	end

	// ------------------------------------------------------------
	// Output pulses
	// ------------------------------------------------------------
	wire leaving = (state == PDWC_RESTART) && restartDone;
	wire next_fullReset = leaving & wakeByExt;
	wire next_watchdogReset = leaving & wakeByWd;
	wire next_resumeNext = leaving & (resumeKind == PDWC_RES_NEXT);
	wire next_vectorIrq = (state == PDWC_VECTOR);
	wire next_watchdogClear = (state == PDWC_RUN) & haltExec;
	// Pulses are registered so the core never sees a decode glitch.
	always_ff @(posedge clock) begin
		if (rst) begin
			fullReset <= 1'b0;
			watchdogReset <= 1'b0;
			resumeNext <= 1'b0;
			vectorIrq <= 1'b0;
			watchdogClear <= 1'b0;
		end else begin
			fullReset <= next_fullReset;
			watchdogReset <= next_watchdogReset;
			resumeNext <= next_resumeNext;
			vectorIrq <= next_vectorIrq;
			watchdogClear <= next_watchdogClear;
		end
	end

	// ------------------------------------------------------------
	// Status flags
	// ------------------------------------------------------------
	// Halt and clear-watchdog never coincide; halt is given priority.
	// An external reset wake outranks a watchdog expiry in one cycle.
	wire wdExpiry = watchdogOverflow & (~inStandby | wdFromRc);
	wire haltNow = (state == PDWC_RUN) & haltExec;
	wire extWakeNow = inStandby & extReset;

	always_ff @(posedge clock) begin
		if (rst || powerUp) begin
			power_down_flag <= 1'b0;
		end else if (haltNow) begin
			power_down_flag <= 1'b1;
		end else if (extWakeNow) begin
			power_down_flag <= 1'b0;
		end else if (clearWatchdog) begin
			power_down_flag <= 1'b0;
		end
	end

	always_ff @(posedge clock) begin
		if (rst || powerUp) begin
			watchdog_expired_flag <= 1'b0;
		end else if (haltNow) begin
			watchdog_expired_flag <= 1'b0;
		end else if (extWakeNow) begin
			watchdog_expired_flag <= 1'b0;
		end else if (wdExpiry) begin
			watchdog_expired_flag <= 1'b1;
		end
	end

	// ------------------------------------------------------------
	// Clock and hold controls
	// ------------------------------------------------------------
	// The oscillator stops only in standby; restart runs on it again.
	// A watchdog on the system clock stops with it; on its RC it runs on.
	assign sysOscEnable = ~inStandby;
	assign coreStall = (state != PDWC_RUN);
	assign holdState = inStandby | (state == PDWC_RESTART);
	assign watchdogRcEnable = ~rcDisabled;
	assign watchdogRun = ~inStandby | wdFromRc;

endmodule : pdwc_power_down_wake_control

// File: verif/pdwc_assertions.sv
// Port-level assertions for the power-down and wake-up sequencer.
// Assumes it is bound to the top module and shares its clock and reset.
`timescale 1ns/100ps
module pdwc_assertions #(
	parameter int RESTART_CYCLES = 8
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic haltExec,
	input wire logic sysOscEnable,
	input wire logic coreStall,
	input wire logic holdState,
	input wire logic watchdogClear,
	input wire logic power_down_flag,
	input wire logic watchdog_expired_flag,
	input wire logic fullReset,
	input wire logic watchdogReset,
	input wire logic resumeNext,
	input wire logic vectorIrq
);
	// Counts restart cycles; standby itself has the oscillator off.
	int rcnt;
	always_ff @(posedge clock) begin
		if (rst || !(holdState && sysOscEnable))
			rcnt <= 0;
		else
			rcnt <= rcnt + 1;
	end
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	property p_halt;
		haltExec && !coreStall |=> !sysOscEnable && power_down_flag
			&& !watchdog_expired_flag && watchdogClear;
	endproperty
	a_halt: assert property (p_halt) else $error("bad halt entry");
	property p_entry;
		$fell(sysOscEnable) |-> $past(haltExec);
	endproperty
	a_entry: assert property (p_entry) else $error("standby no halt");
	property p_stby;
		!sysOscEnable |-> coreStall && holdState;
	endproperty
	a_stby: assert property (p_stby) else $error("standby not held");
	property p_cmax;
		holdState && sysOscEnable |-> rcnt < RESTART_CYCLES;
	endproperty
	a_cmax: assert property (p_cmax) else $error("restart too long");
	property p_cend;
		$fell(holdState) |-> $past(rcnt) == RESTART_CYCLES - 1;
	endproperty
	a_cend: assert property (p_cend) else $error("restart length");
	property p_done;
		$fell(holdState) |-> ##[0:2]
			(fullReset || watchdogReset || resumeNext || vectorIrq);
	endproperty
	a_done: assert property (p_done) else $error("no resume pulse");
	property p_vec;
		vectorIrq |-> $past(coreStall) && !$past(holdState);
	endproperty
	a_vec: assert property (p_vec) else $error("vector too early");
	property p_wdr;
		watchdogReset |-> watchdog_expired_flag && power_down_flag;
	endproperty
	a_wdr: assert property (p_wdr) else $error("watchdog flags");
	property p_full;
		fullReset |-> !power_down_flag && !watchdog_expired_flag;
	endproperty
	a_full: assert property (p_full) else $error("full reset flags");
	c_next: cover property (resumeNext);
	c_vec: cover property (vectorIrq);
	c_wdr: cover property (watchdogReset);
endmodule : pdwc_assertions

// File: verif/pdwc_core_model.sv
// Behavioural core: executes halt on request while it is not stalled.
// Assumes the sequencer's stall output and a single clock.
`timescale 1ns/100ps
module pdwc_core_model (
	input wire logic clock,
	input wire logic rst,
	input wire logic haltReq,
	input wire logic coreStall,
	output logic haltExec
);
	// A stalled core runs no instruction, so it cannot halt then.
	always_ff @(posedge clock) begin
		haltExec <= !rst && haltReq && !coreStall;
	end
endmodule : pdwc_core_model

// File: verif/tb_top.sv
// Self-checking bench for the power-down and wake-up sequencer.
// Assumes the restart count is shortened to 8 cycles.
`timescale 1ns/100ps
module tb_top;
	import pdwc_pkg::*;
	logic clock = 0, rst = 1, powerUp = 0, psel = 0, penable = 0;
	logic pwrite = 0, clearWatchdog = 0, extReset = 0, stackFull = 0;
	logic watchdogOverflow = 0, haltReq = 0, err;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic [7:0] portA = 8'hff;
	logic [3:0] irqRequest = 4'h0, irqEnable = 4'h0, got;
	logic pready, pslverr, haltExec, sysOscEnable, core_freq_select;
	logic watchdogRcEnable, watchdogClear, watchdogRun, coreStall;
	logic holdState, fullReset, watchdogReset, resumeNext, vectorIrq;
	logic power_down_flag, watchdog_expired_flag;
	int miscompares = 0, total_checks = 0;
	pdwc_power_down_wake_control #(.RESTART_CYCLES(8)) uut (.*);
	pdwc_core_model core (.*);
	initial forever #5 clock = ~clock;
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			miscompares++;
			$display("mismatch %s exp %h got %h", n, e, g);
		end
	endtask : chk
	task close_out;
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : close_out
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int i;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		i = 0;
		do begin
			@(posedge clock);
			i++;
		end while (pready !== 1'b1 && i < 20);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		chk("pready", 1, pready);
		@(posedge clock);
		if (i == 20)
			close_out();
	endtask : apb
	task halt;
		haltReq <= 1'b1;
		@(posedge clock);
		haltReq <= 1'b0;
		repeat (2) @(posedge clock);
		chk("osc", 0, sysOscEnable);
		chk("pdown", 1, power_down_flag);
		chk("stall", 1, coreStall);
		chk("hold", 1, holdState);
		chk("wdrun", 1, watchdogRun);
		chk("rcen", 1, watchdogRcEnable);
	endtask : halt
	task waitp(input logic [3:0] e);
		got = 4'h0;
		for (int i = 0; i < 40 && got == 4'h0; i++) begin
			@(posedge clock);
			got = {fullReset, watchdogReset, resumeNext, vectorIrq};
		end
		chk("wake", e, got);
		if (got == 4'h0)
			close_out();
	endtask : waitp
	task sc_regs;
		apb(1'b0, PDWC_CTRL_ADDR, 32'h0);
		chk("ctrl", 32'h4, rd);
		apb(1'b1, PDWC_CTRL_ADDR, 32'h5);
		chk("freq", 1, core_freq_select);
		apb(1'b0, 12'h00c, 32'h0);
		chk("slverr", 1, err);
		apb(1'b1, PDWC_WAKE_ADDR, 32'h1);
		apb(1'b0, PDWC_WAKE_ADDR, 32'h0);
		chk("wakeen", 32'h1, rd);
	endtask : sc_regs
	task sc_port;
		halt();
		portA <= 8'hfd;
		repeat (20) @(posedge clock);
		chk("masked", 0, sysOscEnable);
		portA <= 8'hfc;
		waitp(4'h2);
		portA <= 8'hff;
		clearWatchdog <= 1'b1;
		@(posedge clock);
		clearWatchdog <= 1'b0;
		repeat (2) @(posedge clock);
		chk("pdown", 0, power_down_flag);
	endtask : sc_port
	task sc_irq;
		irqRequest <= 4'h1;
		irqEnable <= 4'h3;
		halt();
		repeat (10) @(posedge clock);
		chk("pend", 0, sysOscEnable);
		irqRequest <= 4'h3;
		waitp(4'h1);
		irqRequest <= 4'h0;
		stackFull <= 1'b1;
		halt();
		irqRequest <= 4'h2;
		waitp(4'h2);
		irqRequest <= 4'h0;
		stackFull <= 1'b0;
	endtask : sc_irq
	task sc_wd;
		halt();
		watchdogOverflow <= 1'b1;
		@(posedge clock);
		watchdogOverflow <= 1'b0;
		waitp(4'h4);
		chk("expired", 1, watchdog_expired_flag);
		powerUp <= 1'b1;
		@(posedge clock);
		powerUp <= 1'b0;
		repeat (2) @(posedge clock);
		chk("up", 0, power_down_flag);
	endtask : sc_wd
	task sc_ext;
		halt();
		extReset <= 1'b1;
		waitp(4'h8);
		extReset <= 1'b0;
		chk("pdown", 0, power_down_flag);
	endtask : sc_ext
	initial begin
		repeat (8) @(posedge clock);
		rst <= 1'b0;
		@(posedge clock);
		sc_regs();
		sc_port();
		sc_irq();
		sc_wd();
		sc_ext();
		close_out();
	end
endmodule : tb_top
bind pdwc_power_down_wake_control pdwc_assertions
	#(.RESTART_CYCLES(RESTART_CYCLES)) chk_i (.*);
